/* sarseq_converter.v */
// successive-approximation converter sequencer with an axi4-lite register slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "sarseq_defs.vh"

// What this block does
// R1 - divider 2..128 chosen by three-bit select
// R2 - divider runs only while enable set
// R3 - start begins at next rising converter clock edge
// R4 - normal conversion lasts 13 converter cycles
// R5 - first conversion after enable lasts 25; here a 25-cycle warm-up run, then a normal 13-cycle conversion
// R6 - extended runs first after enabling, even together
// R7 - sample at 1.5 or 13.5 cycles
// R8 - completion stores result and sets flag
// R9 - single mode clears start; writing zero ignored
// R10 - start reads one until requested conversion ends
// R11 - free run restarts at once, start stays
// R12 - clearing free run stops restarts
// R13 - clearing enable aborts conversion, converter off
// R14 - irq when flag, local and global enables
// R15 - flag cleared by vector or writing one
// R16 - channel field routes input 0..7
// R17 - channel change applies after conversion completes
// R18 - idle entry starts conversion when conditions met
// R19 - idle conversion completion raises waking interrupt
// R20 - ten-bit result split low and high
// R21 - channel register upper five bits read zero
// R22 - low read locks result until high read
// R23 - result writes ignored, high upper bits zero
module sarseq_converter #(
  parameter [4:0] NORMAL_CYCLES        = `SARSEQ_NORMAL_CYCLES,
  parameter [4:0] EXTENDED_CYCLES      = `SARSEQ_EXTENDED_CYCLES,
  parameter [5:0] NORMAL_SAMPLE_HALF   = `SARSEQ_NORMAL_SAMPLE_HALF,
  parameter [5:0] EXTENDED_SAMPLE_HALF = `SARSEQ_EXTENDED_SAMPLE_HALF
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [9:0]  core_result,
  output reg  [2:0]  core_channel,
  output reg         core_sample,
  output reg         core_convert,
  output reg         core_power,
  output reg         converter_clock,
  output reg         irq_request
);

  localparam [1:0] ST_OFF  = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_CONV = 2'h2;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg        converter_enable;
  reg        conversion_start;
  reg        free_run_select;
  reg        conversion_done_flag;
  reg        conversion_done_irq_enable;
  reg [2:0]  clock_divider_select;
  reg [2:0]  channel_select_field;
  reg [7:0]  conversion_result_low;
  reg [1:0]  conversion_result_high;
  reg        result_locked;
  reg        idle_request;
  reg        global_irq_enable;
  reg        need_extended;
  reg        in_extended;
  reg [1:0]  state;
  reg [6:0]  div_count;
  reg [5:0]  half_count;
  reg        idle_armed;
  reg        idle_spent;

  // ---------------------------------------------------------------
  // axi4-lite handshakes
  // ---------------------------------------------------------------
  reg        aw_held;
  reg        w_held;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire       aw_now   = aw_held || s_axi_awvalid;
  wire       w_now    = w_held || s_axi_wvalid;
  wire       wr_fire  = aw_now && w_now && !s_axi_bvalid;
  wire [7:0] wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb  = w_held ? w_strb : s_axi_wstrb;
  wire       wr_lane0 = wr_fire && wr_strb[0];
  wire       rd_fire  = s_axi_arvalid && !s_axi_rvalid;

  wire wr_ctrl = wr_lane0 && (wr_addr == `SARSEQ_ADDR_CTRL_STATUS);
  wire wr_chan = wr_lane0 && (wr_addr == `SARSEQ_ADDR_CHAN_SELECT);
  wire wr_sys  = wr_lane0 && (wr_addr == `SARSEQ_ADDR_SYSTEM);
  wire wr_known = (wr_addr == `SARSEQ_ADDR_RESULT_LOW) ||
                  (wr_addr == `SARSEQ_ADDR_RESULT_HIGH) ||
                  (wr_addr == `SARSEQ_ADDR_CTRL_STATUS) ||
                  (wr_addr == `SARSEQ_ADDR_CHAN_SELECT) ||
                  (wr_addr == `SARSEQ_ADDR_SYSTEM);

  // ---------------------------------------------------------------
  // converter clock divider
  // ---------------------------------------------------------------
  reg [6:0] div_half;
  always @* begin
    case (clock_divider_select) // R1
      3'h0, 3'h1: div_half = 7'h01;
      3'h2:       div_half = 7'h02;
      3'h3:       div_half = 7'h04;
      3'h4:       div_half = 7'h08;
      3'h5:       div_half = 7'h10;
      3'h6:       div_half = 7'h20;
      default:    div_half = 7'h40;
    endcase
  end

  // one pulse per half period of the divided clock
  wire half_tick = converter_enable && (div_count >= div_half - 7'h01);
  wire rise_tick = half_tick && !converter_clock;

  always @(posedge aclk) begin
    if (!aresetn || !converter_enable) begin // R2
      div_count       <= 7'h00;
      converter_clock <= 1'b0;
    end else if (half_tick) begin
      div_count       <= 7'h00;
      converter_clock <= !converter_clock;
    end else begin
      div_count <= div_count + 7'h01;
    end
  end

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  wire [5:0] end_half    = in_extended ? {EXTENDED_CYCLES, 1'b0}
                                       : {NORMAL_CYCLES, 1'b0};
  wire [5:0] sample_half = in_extended ? EXTENDED_SAMPLE_HALF
                                       : NORMAL_SAMPLE_HALF;
  wire       conv_end    = (state == ST_CONV) && half_tick &&
                           (half_count == end_half - 6'h01);
  wire       real_done   = conv_end && !in_extended;
  wire       write_start = wr_ctrl && wr_data[`SARSEQ_BIT_START];
  wire       write_enable = wr_ctrl && wr_data[`SARSEQ_BIT_ENABLE];
  wire       idle_ready  = converter_enable && !conversion_start &&
                           !free_run_select && conversion_done_irq_enable;
  wire       idle_start  = idle_request && idle_armed && !idle_spent && idle_ready &&
                           (state == ST_OFF);
  wire       vector_ack  = wr_sys && wr_data[`SARSEQ_BIT_SYS_VACK];

  always @(posedge aclk) begin
    if (!aresetn) begin
      converter_enable           <= 1'b0;
      conversion_start           <= 1'b0;
      free_run_select            <= 1'b0;
      conversion_done_flag       <= 1'b0;
      conversion_done_irq_enable <= 1'b0;
      clock_divider_select       <= 3'h0;
      channel_select_field       <= `SARSEQ_RESET_CHAN;
      core_channel               <= `SARSEQ_RESET_CHAN;
      conversion_result_low      <= 8'h00;
      conversion_result_high     <= 2'h0;
      idle_request               <= 1'b0;
      global_irq_enable          <= 1'b0;
      need_extended              <= 1'b1;
      in_extended                <= 1'b0;
      state                      <= ST_OFF;
      half_count                 <= 6'h00;
      core_sample                <= 1'b0;
      core_convert               <= 1'b0;
      irq_request                <= 1'b0;
    end else begin
      core_sample <= 1'b0;
      if (wr_ctrl) begin
        converter_enable           <= wr_data[`SARSEQ_BIT_ENABLE];
        free_run_select            <= wr_data[`SARSEQ_BIT_FREE_RUN]; // R12
        conversion_done_irq_enable <= wr_data[`SARSEQ_BIT_IRQ_ENABLE];
        clock_divider_select       <= wr_data[2:0];
      end
      if (wr_chan)
        channel_select_field <= wr_data[2:0];
      if (wr_sys) begin
        global_irq_enable <= wr_data[`SARSEQ_BIT_SYS_GIE];
        idle_request      <= wr_data[`SARSEQ_BIT_SYS_IDLE];
      end
      // flag: set beats either clear
      if (real_done)
        conversion_done_flag <= 1'b1; // R8
      else if (vector_ack || (wr_ctrl && wr_data[`SARSEQ_BIT_DONE_FLAG]))
        conversion_done_flag <= 1'b0; // R15
      // start bit: zero writes ignored
      if (write_start && (converter_enable || write_enable))
        conversion_start <= 1'b1; // R9
      if (idle_start)
        conversion_start <= 1'b1; // R18
      if (wr_ctrl && !wr_data[`SARSEQ_BIT_ENABLE]) begin
        state            <= ST_OFF; // R13
        conversion_start <= 1'b0;
        core_convert     <= 1'b0;
        need_extended    <= 1'b1;
        in_extended      <= 1'b0;
      end else begin
        case (state)
          ST_OFF: begin
            if ((write_start && (converter_enable || write_enable)) || idle_start) begin
              state <= ST_WAIT; // R3
            end
          end
          ST_WAIT: begin
            if (rise_tick) begin
              state        <= ST_CONV;
              half_count   <= 6'h00;
              in_extended  <= need_extended; // R6 R5
              need_extended <= 1'b0;
              core_convert <= 1'b1;
              core_channel <= channel_select_field; // R16
            end
          end
          ST_CONV: begin
            if (half_tick)
              half_count <= half_count + 6'h01;
            if (half_tick && (half_count == sample_half - 6'h01))
              core_sample <= 1'b1; // R7
            if (conv_end) begin // R4
              half_count   <= 6'h00;
              // warm-up run keeps the channel of the request behind it
              if (!in_extended)
                core_channel <= channel_select_field; // R17
              if (in_extended) begin
                in_extended <= 1'b0; // R10
              end else if (free_run_select) begin
                core_convert <= 1'b1; // R11
              end else begin
                state            <= ST_OFF;
                core_convert     <= 1'b0;
                conversion_start <= 1'b0; // R9
              end
              if (real_done && !result_locked) begin
                conversion_result_low  <= core_result[7:0]; // R20
                conversion_result_high <= core_result[9:8];
              end
            end
          end
          default: state <= ST_OFF;
        endcase
      end
      // irq is also the idle wake-up
      irq_request <= (conversion_done_flag || real_done) &&
                     conversion_done_irq_enable && global_irq_enable; // R14 R19
    end
  end

  // ---------------------------------------------------------------
  // idle entry: one noise-cancelling conversion per halt
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      idle_armed <= 1'b0;
      idle_spent <= 1'b0;
    end else begin
      // halt is seen one cycle after idle entry
      idle_armed <= idle_request && !(wr_sys && !wr_data[`SARSEQ_BIT_SYS_IDLE]);
      // a fresh idle write re-arms; otherwise the wake-up would restart it
      if (wr_sys)
        idle_spent <= 1'b0;
      else if (idle_start)
        idle_spent <= 1'b1; // R18
    end
  end

  always @(posedge aclk) begin
    if (!aresetn)
      core_power <= 1'b0;
    else
      core_power <= converter_enable; // R13
  end

  // ---------------------------------------------------------------
  // read path and result lock
  // ---------------------------------------------------------------
  reg [7:0] rd_value;
  reg       rd_known;
  always @* begin
    rd_known = 1'b1;
    if (s_axi_araddr == `SARSEQ_ADDR_RESULT_LOW)
      rd_value = conversion_result_low;
    else if (s_axi_araddr == `SARSEQ_ADDR_RESULT_HIGH)
      rd_value = {6'h00, conversion_result_high}; // R23
    else if (s_axi_araddr == `SARSEQ_ADDR_CTRL_STATUS)
      rd_value = {converter_enable, conversion_start, free_run_select,
                  conversion_done_flag, conversion_done_irq_enable, clock_divider_select};
    else if (s_axi_araddr == `SARSEQ_ADDR_CHAN_SELECT)
      rd_value = {5'h00, channel_select_field}; // R21
    else if (s_axi_araddr == `SARSEQ_ADDR_SYSTEM)
      rd_value = {6'h00, global_irq_enable, idle_request};
    else begin
      rd_value = 8'h00;
      rd_known = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      result_locked <= 1'b0;
    end else if (rd_fire && (s_axi_araddr == `SARSEQ_ADDR_RESULT_LOW)) begin
      result_locked <= 1'b1; // R22
    end else if (rd_fire && (s_axi_araddr == `SARSEQ_ADDR_RESULT_HIGH)) begin
      result_locked <= 1'b0; // R22
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SARSEQ_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SARSEQ_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // result registers answer okay but ignore the data
        s_axi_bresp  <= wr_known ? `SARSEQ_RESP_OKAY : `SARSEQ_RESP_SLVERR; // R23
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_value};
        s_axi_rresp  <= rd_known ? `SARSEQ_RESP_OKAY : `SARSEQ_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // sarseq_converter

/* sarseq_defs.vh */
// constants for the converter sequencer: offsets, fields, timing
`ifndef SARSEQ_DEFS_VH
`define SARSEQ_DEFS_VH
// register indices (printed offsets are not all multiples of four)
`define SARSEQ_IDX_RESULT_LOW   8'h04
`define SARSEQ_IDX_RESULT_HIGH  8'h05
`define SARSEQ_IDX_CTRL_STATUS  8'h06
`define SARSEQ_IDX_CHAN_SELECT  8'h07
// byte address = index * 4
`define SARSEQ_ADDR_RESULT_LOW  8'h10
`define SARSEQ_ADDR_RESULT_HIGH 8'h14
`define SARSEQ_ADDR_CTRL_STATUS 8'h18
`define SARSEQ_ADDR_CHAN_SELECT 8'h1C
`define SARSEQ_ADDR_SYSTEM      8'h20
// control/status field positions
`define SARSEQ_BIT_ENABLE       7
`define SARSEQ_BIT_START        6
`define SARSEQ_BIT_FREE_RUN     5
`define SARSEQ_BIT_DONE_FLAG    4
`define SARSEQ_BIT_IRQ_ENABLE   3
// system register bits: idle request, global interrupt enable, vector ack
`define SARSEQ_BIT_SYS_IDLE     0
`define SARSEQ_BIT_SYS_GIE      1
`define SARSEQ_BIT_SYS_VACK     2
`define SARSEQ_RESET_CTRL       8'h00
`define SARSEQ_RESET_CHAN       3'h0
// conversion lengths in converter clock cycles
`define SARSEQ_NORMAL_CYCLES    5'h0D
`define SARSEQ_EXTENDED_CYCLES  5'h19
// sample point in converter half cycles: 1.5 and 13.5 cycles
`define SARSEQ_NORMAL_SAMPLE_HALF   6'h03
`define SARSEQ_EXTENDED_SAMPLE_HALF 6'h1B
// axi responses
`define SARSEQ_RESP_OKAY        2'h0
`define SARSEQ_RESP_SLVERR      2'h2
`endif

/* sarseq_sva.sv */
// concurrent checks on the converter sequencer ports
`timescale 1ns/100ps
module sarseq_sva (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        core_sample,
  input wire        core_convert,
  input wire        core_power,
  input wire        converter_clock,
  input wire        irq_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sample_pulse_a: assert property (core_sample |=> !core_sample)
    else $error("sample pulse longer than one cycle");
  sample_busy_a: assert property (core_sample |-> core_convert)
    else $error("sample outside a conversion");
  convert_power_a: assert property (core_convert |-> core_power)
    else $error("conversion while converter off");
  clock_idle_a: assert property (!core_power [*3] |-> !converter_clock)
    else $error("converter clock runs while disabled");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
  sample_c: cover property (core_sample);
  irq_c: cover property ($rose(irq_request));
  power_c: cover property ($fell(core_power));
endmodule // sarseq_sva

bind sarseq_converter sarseq_sva chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .core_sample(core_sample), .core_convert(core_convert), .core_power(core_power),
  .converter_clock(converter_clock), .irq_request(irq_request));

/* sarseq_core_model.sv */
// behavioural analog core: code tied to the sampled channel
`timescale 1ns/100ps
module sarseq_core_model (
  input  wire       aclk,
  input  wire [2:0] core_channel,
  input  wire       core_sample,
  input  wire       core_convert,
  output wire [9:0] core_result
);
  reg [9:0] held = 10'h000;
  always @(posedge aclk) begin
    if (core_sample)
      held <= {core_channel, 7'h2A};
  end
  // outside a conversion the code is not valid, so show its inverse
  assign core_result = core_convert ? held : ~held;
endmodule // sarseq_core_model

/* sarseq_tb.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
`include "sarseq_defs.vh"
module testbench;
  localparam [7:0] a_lo = `SARSEQ_ADDR_RESULT_LOW;
  localparam [7:0] a_hi = `SARSEQ_ADDR_RESULT_HIGH;
  localparam [7:0] a_cs = `SARSEQ_ADDR_CTRL_STATUS;
  localparam [7:0] a_ch = `SARSEQ_ADDR_CHAN_SELECT;
  localparam [7:0] a_sy = `SARSEQ_ADDR_SYSTEM;
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h00000000, v;
  logic [1:0]  r;
  logic [9:0]  e;
  logic        ck_q = 0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [9:0]  core_result;
  wire  [2:0]  core_channel;
  wire         core_sample, core_convert, core_power, converter_clock, irq_request;
  integer      failures = 0, cmp_count = 0, cyc = 0, samp_n = 0, samp_gap = 0;
  integer      samp_t = 0, ck_gap = 0, ck_t = 0, i, c0;
  always #2 aclk = ~aclk;
  sarseq_converter dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .core_result(core_result), .core_channel(core_channel),
    .core_sample(core_sample), .core_convert(core_convert), .core_power(core_power),
    .converter_clock(converter_clock), .irq_request(irq_request));
  sarseq_core_model core (.aclk(aclk), .core_channel(core_channel),
    .core_sample(core_sample), .core_convert(core_convert), .core_result(core_result));
  // ----------------------------------------
  // monitors and bus tasks
  // ----------------------------------------
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    ck_q <= converter_clock;
    if (converter_clock && !ck_q)
      ck_gap <= cyc - ck_t;
    if (converter_clock && !ck_q)
      ck_t <= cyc;
    if (core_sample)
      samp_gap <= cyc - samp_t;
    if (core_sample)
      samp_t <= cyc;
    if (core_sample)
      samp_n <= samp_n + 1;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // handshakes are judged at the falling edge, acted on at the rising one
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, b;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 0;
    while (!b) begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    logic ar, b;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    b = 0;
    while (!b) begin
      @(negedge aclk);
      ar = arvalid && arready;
      b = rvalid;
      v = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task wait_done;
    integer n;
    n = 0;
    v = 0;
    while (!v[4] && n < 300) begin
      rd(a_cs);
      n++;
    end
    chk(v[4], 1);
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    results;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(a_cs);
    chk(v, 32'h00000000);
    wr(a_ch, 8'hFF);
    rd(a_ch);
    chk(v, 32'h00000007);
    rd(8'h3C);
    chk(r, `SARSEQ_RESP_SLVERR);
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      wr(a_cs, 8'h80 | i[7:0]);
      repeat (300) @(posedge aclk);
      chk(ck_gap, (i < 2) ? 2 : (1 << i));
      wr(a_cs, 8'h00);
      repeat (4) @(posedge aclk);
      chk(converter_clock, 0);
    end
    $display("test divider done");
    wr(a_cs, 8'h80);
    for (i = 0; i < 8; i++) begin
      e = {i[2:0], 7'h2A};
      c0 = samp_n;
      wr(a_ch, i[7:0]);
      wr(a_cs, 8'hC0);
      rd(a_cs);
      chk(v[6], 1);
      wr(a_ch, ~i[7:0]);
      wait_done;
      chk(v[6], 0);
      chk(samp_n - c0, (i == 0) ? 2 : 1);
      rd(a_lo);
      chk(v, e[7:0]);
      rd(a_hi);
      chk(v, e[9:8]);
      wr(a_cs, 8'h90);
      rd(a_cs);
      chk(v[4], 0);
    end
    rd(a_lo);
    wr(a_ch, 8'h00);
    wr(a_cs, 8'hC0);
    wait_done;
    rd(a_hi);
    chk(v, 32'h00000003);
    wr(a_hi, 8'hFC);
    chk(r, `SARSEQ_RESP_OKAY);
    rd(a_hi);
    chk(v, 32'h00000003);
    $display("test single done");
    wr(a_cs, 8'hF2);
    repeat (400) @(posedge aclk);
    chk(samp_gap, 52);
    rd(a_cs);
    chk(v[6], 1);
    wr(a_cs, 8'h92);
    repeat (120) @(posedge aclk);
    c0 = samp_n;
    repeat (200) @(posedge aclk);
    chk(samp_n - c0, 0);
    wr(a_cs, 8'h90);
    wr(a_cs, 8'hC0);
    repeat (10) @(posedge aclk);
    wr(a_cs, 8'h00);
    repeat (3) @(posedge aclk);
    chk({core_convert, core_power}, 0);
    rd(a_cs);
    chk(v[4], 0);
    $display("test free run and abort done");
    wr(a_cs, 8'h88);
    wr(a_sy, 8'h02);
    chk(irq_request, 0);
    wr(a_sy, 8'h03);
    c0 = 0;
    while (!irq_request && c0 < 400) begin
      @(posedge aclk);
      c0++;
    end
    chk(irq_request, 1);
    wr(a_sy, 8'h06);
    repeat (2) @(posedge aclk);
    chk(irq_request, 0);
    chk(core_convert, 0);
    wr(a_cs, 8'h80);
    wr(a_cs, 8'hC0);
    wait_done;
    chk(irq_request, 0);
    $display("test interrupt done");
    results;
  end
endmodule // testbench
